// File: hdl/adcps_seq.sv
// calibration and power sequencer for the converter
`timescale 1ns/1ps
`default_nettype none
module adcps_seq #(
  parameter int FULL_CYC   = adcps_pkg::CAL_FULL_CYC,
  parameter int GO_CYC     = adcps_pkg::CAL_GO_CYC,
  parameter int SINGLE_CYC = adcps_pkg::CAL_SINGLE_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                masterClock,
  input  wire logic                calPinN,
  input  wire logic                sleepPinN,
  input  wire logic                swWrite,
  input  wire adcps_pkg::adcps_wr_t swWrData,
  input  wire logic                converting,
  input  wire logic                convReq,
  output logic                     convGrant,
  output logic                     busy,
  output logic                     calInternalReset,
  output adcps_pkg::adcps_trim_t   trim,
  output logic                     fullPowerDown,
  output logic                     partialPowerDown
);

  adcps_pkg::adcps_regs_t r_r;
  adcps_pkg::adcps_regs_t r_nxt;
  logic                   mclkTick;

  // phase lengths in master clock cycles, loaded minus one
  function automatic logic [16:0] phaseLen(input adcps_pkg::adcps_state_t s,
                                           input logic [1:0] t);
    int len;
    len = SINGLE_CYC;
    if (s == adcps_pkg::ST_DAC) len = FULL_CYC - GO_CYC;
    else if (s == adcps_pkg::ST_GAIN && t != adcps_pkg::CAL_GAIN) len = GO_CYC - SINGLE_CYC;
    phaseLen = 17'(len - 1);
  endfunction : phaseLen

  // first trim phase of each calibration type
  function automatic adcps_pkg::adcps_state_t firstPhase(input logic [1:0] t);
    case (t)
      adcps_pkg::CAL_FULL:   firstPhase = adcps_pkg::ST_DAC;
      adcps_pkg::CAL_OFFSET: firstPhase = adcps_pkg::ST_OFFSET;
      default:               firstPhase = adcps_pkg::ST_GAIN;
    endcase
  endfunction : firstPhase

  // next state
  always_comb begin
    r_nxt = r_r;
    // durations advance only on master clock rising edges
    mclkTick = masterClock & ~r_r.mclkPrev;
    r_nxt.mclkPrev = masterClock;
    // power bits land on every write, even mid-calibration
    if (swWrite) begin
      r_nxt.pm = {swWrData.powerManageHiBit, swWrData.powerManageLoBit};
    end
    // type bits are kept for later pin starts; a running calibration keeps its own
    if (swWrite && !r_r.busy) begin
      r_nxt.calType = swWrData.calType;
    end
    case (r_r.st)
      adcps_pkg::ST_POWERON: begin
        // pin already high means autocal is strapped off
        r_nxt.porFull = ~calPinN;
        r_nxt.st      = calPinN ? adcps_pkg::ST_IDLE : adcps_pkg::ST_HOLD;
      end
      adcps_pkg::ST_IDLE: begin
        // a start while the pin is low loses to the abort below
        if (swWrite && swWrData.startCalibrationBit) begin
          r_nxt.calType = swWrData.calType;
          r_nxt.st      = firstPhase(swWrData.calType);
          r_nxt.cnt     = phaseLen(firstPhase(swWrData.calType), swWrData.calType);
        end
      end
      adcps_pkg::ST_HOLD: begin
        if (calPinN) begin
          // first release after power-on forces a full self-calibration
          r_nxt.calType = r_r.porFull ? adcps_pkg::CAL_FULL : r_r.calType;
          r_nxt.porFull = 1'b0;
          r_nxt.st      = firstPhase(r_nxt.calType);
          r_nxt.cnt     = phaseLen(firstPhase(r_nxt.calType), r_nxt.calType);
        end
      end
      adcps_pkg::ST_DAC, adcps_pkg::ST_GAIN, adcps_pkg::ST_OFFSET: begin
        if (mclkTick && r_r.cnt != 17'h0) begin
          r_nxt.cnt = r_r.cnt - 17'h1;
        end else if (mclkTick) begin
          // dac, then gain, then offset; singles stop after one
          if (r_r.st == adcps_pkg::ST_DAC) begin
            r_nxt.st = adcps_pkg::ST_GAIN;
          end else if (r_r.st == adcps_pkg::ST_GAIN && r_r.calType != adcps_pkg::CAL_GAIN) begin
            r_nxt.st = adcps_pkg::ST_OFFSET;
          end else begin
            r_nxt.st = adcps_pkg::ST_IDLE;
          end
          // each phase reloads its own length, so the split never drifts
          r_nxt.cnt = phaseLen(r_nxt.st, r_r.calType);
        end
      end
      default: r_nxt.st = adcps_pkg::ST_IDLE;
    endcase
    // pin low aborts anything and holds the logic in reset
    if (!calPinN && r_r.st != adcps_pkg::ST_POWERON) begin
      r_nxt.st  = adcps_pkg::ST_HOLD;
      r_nxt.cnt = 17'h0;
    end
    // status decoded from next state so outputs are flops
    r_nxt.busy = r_nxt.st inside {adcps_pkg::ST_DAC, adcps_pkg::ST_GAIN,
                                  adcps_pkg::ST_OFFSET};
    r_nxt.intReset    = r_nxt.st == adcps_pkg::ST_HOLD;
    r_nxt.trim.dac    = r_nxt.st == adcps_pkg::ST_DAC;
    r_nxt.trim.gain   = r_nxt.st == adcps_pkg::ST_GAIN; // positive full scale
    r_nxt.trim.offset = r_nxt.st == adcps_pkg::ST_OFFSET; // zero scale
    // power modes; sleep pin only matters in the default code
    r_nxt.fullDown = (r_nxt.pm == adcps_pkg::PM_FULL_DOWN) ||
                     (r_nxt.pm == adcps_pkg::PM_SLEEP_CTRL && !sleepPinN &&
                      !r_nxt.busy && !converting);
    r_nxt.partDown = (r_nxt.pm == adcps_pkg::PM_PARTIAL) && !converting;
  end

  // state register
  // reset loads constants only; the power-on state then samples the pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r          <= '0;
      r_r.st       <= adcps_pkg::ST_POWERON;
      r_r.pm       <= adcps_pkg::PM_RESET;
      r_r.calType  <= adcps_pkg::CAL_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  // conversions wait while calibrating or held in reset
  assign convGrant        = convReq & ~r_r.busy & ~r_r.intReset;
  assign busy             = r_r.busy;
  assign calInternalReset = r_r.intReset;
  assign trim             = r_r.trim;
  assign fullPowerDown    = r_r.fullDown;
  assign partialPowerDown = r_r.partDown;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence sPinRelease;
    calInternalReset ##1 calPinN;
  endsequence

  sequence sSwStart;
    swWrite && swWrData.startCalibrationBit && !busy && !calInternalReset &&
      r_r.st == adcps_pkg::ST_IDLE && calPinN;
  endsequence

  // a phase ends on the master tick that finds its count at zero, pin still high
  sequence sPhaseEnd;
    mclkTick && r_r.cnt == 17'h0 && calPinN;
  endsequence

  // both start paths raise busy one edge after they are taken
  AST_SW_START: assert property (sSwStart |=> busy)
    else $error("software start did not raise busy");
  AST_PIN_RELEASE: assert property (sPinRelease |=> busy && !calInternalReset)
    else $error("pin release did not start calibration");
  AST_PIN_LOW: assert property (!calPinN && r_r.st != adcps_pkg::ST_POWERON
                                |=> !busy && calInternalReset)
    else $error("pin low did not abort into reset");
  AST_NO_GRANT: assert property (busy |-> !convGrant)
    else $error("conversion granted during calibration");
  // phase order; the pin level that counts is the one seen as the phase was left
  AST_DAC_TO_GAIN: assert property ($fell(trim.dac) && $past(calPinN)
                                    |-> trim.gain && busy)
    else $error("dac trim not followed by gain trim");
  AST_GAIN_TO_OFF: assert property ($fell(trim.gain) && $past(calPinN) &&
                                    r_r.calType != adcps_pkg::CAL_GAIN |-> trim.offset)
    else $error("gain trim not followed by offset trim");
  // counting stalls between master clock edges, however fast ref_clk runs
  AST_HOLD_COUNT: assert property (busy && !mclkTick && calPinN
                                   |=> busy && $stable(r_r.cnt))
    else $error("calibration advanced without master clock");
  AST_BUSY_STAYS: assert property (busy && r_r.cnt != 17'h0 && calPinN |=> busy)
    else $error("busy fell before count expired");
  AST_PM_DOWN: assert property (r_r.pm == adcps_pkg::PM_FULL_DOWN |-> fullPowerDown)
    else $error("full power-down code ignored");
  AST_PM_NORMAL: assert property (r_r.pm == adcps_pkg::PM_NORMAL
                                  |-> !fullPowerDown && !partialPowerDown)
    else $error("normal code powered down");
  AST_POR_FULL: assert property (r_r.porFull && r_r.intReset ##1 calPinN
                                 |=> trim.dac)
    else $error("power-on release did not start full calibration");

  // a low pin straight out of reset is the capacitor still charging: hold and arm autocal
  AST_POR_HOLD: assert property (r_r.st == adcps_pkg::ST_POWERON && !calPinN
                                 |=> calInternalReset && r_r.porFull)
    else $error("power-on with pin low did not hold");

  // exactly one trim phase runs while busy is up, none otherwise
  AST_TRIM_BUSY: assert property ($onehot0(trim) && ((trim != 3'h0) == busy))
    else $error("trim phase and busy disagree");

  // the last phase of each type ends the calibration on its final master tick
  AST_OFFSET_LAST: assert property (trim.offset ##0 sPhaseEnd
                                    |=> !busy && !calInternalReset)
    else $error("offset trim did not end the calibration");
  AST_GAIN_ONLY_END: assert property (trim.gain && r_r.calType == adcps_pkg::CAL_GAIN
                                      ##0 sPhaseEnd |=> !busy && !trim.offset)
    else $error("gain-only calibration ran on");

  // sleep-pin power-down waits for the calibration to finish
  AST_SLEEP_CAL: assert property (busy && r_r.pm == adcps_pkg::PM_SLEEP_CTRL
                                  |-> !fullPowerDown)
    else $error("sleep pin powered down a running calibration");
  // partial power-down follows its code and the converter one cycle late
  AST_PARTIAL: assert property (partialPowerDown ==
                                (r_r.pm == adcps_pkg::PM_PARTIAL && !$past(converting)))
    else $error("partial power-down does not follow its code");

  // outside calibration and hold a conversion request passes straight through
  AST_IDLE_GRANT: assert property (!busy && !calInternalReset
                                   |-> convGrant == convReq)
    else $error("idle conversion request not granted");

endmodule : adcps_seq
`default_nettype wire

// File: include/adcps_pkg.sv
// package for the converter calibration and power sequencer
//
// Contract
// - calibration starts on calibration pin pulse or software write with start bit set.
// - at 4 MHz master clock: full 31.25 ms, gain+offset 6.94 ms, single 3.47 ms.
// - calibration lengths count master clock cycles, so slower clocks stretch them.
// - at power-on a full self-calibration starts once the calibration pin rises.
// - calibration pin low resets converter logic; calibration begins when it returns high.
// - busy rises at pin release or after the write, stays up until done.
// - full trims DAC, gain, offset; gain+offset skips DAC; singles trim one.
// - offset trims the zero-scale error, gain trims the positive full-scale error.
// - full power-down after conversion keeps the device powered only while converting; code 10 here holds full power-down even during a conversion.
// - power bits 00 sleep-controlled, 01 normal, 10 full down, 11 partial.
package adcps_pkg;

  // calibration times at the reference master clock
  localparam real MCLK_REF_MHZ  = 4.0;
  localparam real CAL_FULL_MS   = 31.25;
  localparam real CAL_GO_MS     = 6.94;
  localparam real CAL_SINGLE_MS = 3.47;
  localparam int  CAL_FULL_CYC   = int'(CAL_FULL_MS * 1000.0 * MCLK_REF_MHZ);
  localparam int  CAL_GO_CYC     = int'(CAL_GO_MS * 1000.0 * MCLK_REF_MHZ);
  localparam int  CAL_SINGLE_CYC = int'(CAL_SINGLE_MS * 1000.0 * MCLK_REF_MHZ);
  localparam int  CNT_W          = 17;

  // calibration type codes
  localparam logic [1:0] CAL_FULL        = 2'h0;
  localparam logic [1:0] CAL_GAIN_OFFSET = 2'h1;
  localparam logic [1:0] CAL_OFFSET      = 2'h2;
  localparam logic [1:0] CAL_GAIN        = 2'h3;

  // power management codes {hi, lo}
  localparam logic [1:0] PM_SLEEP_CTRL = 2'h0;
  localparam logic [1:0] PM_NORMAL     = 2'h1;
  localparam logic [1:0] PM_FULL_DOWN  = 2'h2;
  localparam logic [1:0] PM_PARTIAL    = 2'h3;

  // values after reset
  localparam logic [1:0] PM_RESET  = PM_SLEEP_CTRL;
  localparam logic [1:0] CAL_RESET = CAL_FULL;

  typedef enum logic [2:0] {
    ST_POWERON,
    ST_IDLE,
    ST_HOLD,
    ST_DAC,
    ST_GAIN,
    ST_OFFSET
  } adcps_state_t;

  // one control register write
  typedef struct packed {
    logic       startCalibrationBit;
    logic [1:0] calType;
    logic       powerManageHiBit;
    logic       powerManageLoBit;
  } adcps_wr_t;

  // trim phase indicators
  typedef struct packed {
    logic dac;
    logic gain;
    logic offset;
  } adcps_trim_t;

  typedef struct packed {
    adcps_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [1:0]   calType;
    logic [1:0]   pm;
    logic         porFull;
    logic         mclkPrev;
    logic         busy;
    logic         intReset;
    adcps_trim_t  trim;
    logic         fullDown;
    logic         partDown;
  } adcps_regs_t;

endpackage : adcps_pkg

// File: tb/adcps_host.sv
// host model: master clock source, calibration pin and control writes
`timescale 1ns/1ps
`default_nettype none
module adcps_host (
  input  wire logic            ref_clk,
  output logic                 masterClock,
  output logic                 calPinN,
  output logic                 swWrite,
  output adcps_pkg::adcps_wr_t swWrData
);
  int half = 2;
  int ph   = 0;
  // pin starts low while its capacitor charges, keeping calibration off until then
  initial begin
    masterClock = 1'b0;
    calPinN     = 1'b0;
    swWrite     = 1'b0;
    swWrData    = '0;
  end
  // divided master clock, always below half the sampling rate
  always @(posedge ref_clk) begin
    if (ph >= half - 1) begin
      ph <= 0;
      masterClock <= #1 ~masterClock;
    end else ph <= ph + 1;
  end
  // pin edges, the low time is chosen by the caller
  task automatic cal_set(input logic v);
    @(posedge ref_clk) #1 calPinN = v;
  endtask : cal_set
  // one-cycle write strobe with its data
  task automatic reg_write(input logic st, input logic [1:0] ty, input logic [1:0] pm);
    @(posedge ref_clk) #1 swWrite = 1'b1;
    swWrData = '{st, ty, pm[1], pm[0]};
    @(posedge ref_clk) #1 swWrite = 1'b0;
  endtask : reg_write
endmodule : adcps_host
`default_nettype wire

// File: tb/test_adcps_seq.sv
// self-checking bench for the calibration and power sequencer
`timescale 1ns/1ps
`default_nettype none
module test_adcps_seq;
  localparam int FULL  = 40;
  localparam int GO    = 12;
  localparam int SGL   = 6;
  localparam int PWRUP = 1000; // 5 us at 200 MHz
  logic                   ref_clk, rst_n, sleepPinN, converting, convReq;
  logic                   masterClock, calPinN, swWrite, convGrant, busy;
  logic                   calInternalReset, fullPowerDown, partialPowerDown;
  adcps_pkg::adcps_wr_t   swWrData;
  adcps_pkg::adcps_trim_t trim;
  int                     fails = 0;
  int                     cmp_count = 0;
  int                     cyc = 0;
  adcps_seq #(.FULL_CYC(FULL), .GO_CYC(GO), .SINGLE_CYC(SGL)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .masterClock(masterClock), .calPinN(calPinN),
    .sleepPinN(sleepPinN), .swWrite(swWrite), .swWrData(swWrData),
    .converting(converting), .convReq(convReq), .convGrant(convGrant), .busy(busy),
    .calInternalReset(calInternalReset), .trim(trim), .fullPowerDown(fullPowerDown),
    .partialPowerDown(partialPowerDown));
  adcps_host host (.ref_clk(ref_clk), .masterClock(masterClock), .calPinN(calPinN),
    .swWrite(swWrite), .swWrData(swWrData));
  task automatic print_verdict();
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk_val(input string nm, input logic [2:0] e, input logic [2:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  // tolerance covers the master clock phase at start and finish
  task automatic chk_len(input string nm, input int e, input int g, input int tol);
    cmp_count++;
    if (g < e - tol || g > e + tol) begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_len
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // follow one calibration to its end, collecting the trim phases seen
  task automatic run_cal(input int ticks, input logic [2:0] mask);
    int n;
    logic [2:0] seen;
    n = 0;
    seen = '0;
    while (busy === 1'b1 && n < 4000) begin
      seen |= {trim.dac, trim.gain, trim.offset};
      n++;
      tick(1);
    end
    chk_val("trim phases", mask, seen);
    chk_len("busy cycles", ticks * 2 * host.half, n, 2 * host.half + 2);
  endtask : run_cal
  // power-on: a type written in hold must not stop the forced full run
  task automatic t_poweron();
    chk_val("hold reset", 3'h1, {2'h0, calInternalReset});
    host.reg_write(1'b0, 2'h2, 2'h1);
    host.cal_set(1'b1);
    tick(1);
    chk_val("busy on rise", 3'h1, {2'h0, busy});
    run_cal(FULL, 3'h7);
  endtask : t_poweron
  task automatic t_sw_types();
    int lens [4] = '{FULL, GO, SGL, SGL};
    logic [2:0] masks [4] = '{3'h7, 3'h3, 3'h1, 3'h2};
    for (int i = 0; i < 4; i++) begin
      host.reg_write(1'b1, 2'(i), 2'h1);
      chk_val("busy after write", 3'h1, {2'h0, busy});
      run_cal(lens[i], masks[i]);
    end
  endtask : t_sw_types
  // halving the master clock must double the time
  task automatic t_slow();
    host.half = 4;
    host.reg_write(1'b1, 2'h3, 2'h1);
    run_cal(SGL, 3'h2);
    host.half = 2;
  endtask : t_slow
  // pin start takes the type stored by an earlier non-start write
  task automatic t_pin_type();
    host.reg_write(1'b0, 2'h1, 2'h1);
    host.cal_set(1'b0);
    tick(PWRUP);
    host.cal_set(1'b1);
    tick(1);
    run_cal(GO, 3'h3);
  endtask : t_pin_type
  // requests ignored while busy, pin low aborts and restarts
  task automatic t_refuse();
    host.reg_write(1'b1, 2'h0, 2'h1);
    tick(10);
    // a gain-only start mid-run must neither restart nor retype the run
    host.reg_write(1'b1, 2'h3, 2'h1);
    convReq = 1'b1;
    #1 chk_val("grant while busy", 3'h0, {2'h0, convGrant});
    host.cal_set(1'b0);
    tick(1);
    chk_val("abort", 3'h2, {busy, calInternalReset, convGrant});
    tick(PWRUP);
    host.cal_set(1'b1);
    tick(1);
    run_cal(FULL, 3'h7);
    chk_val("grant idle", 3'h1, {2'h0, convGrant});
    convReq = 1'b0;
  endtask : t_refuse
  // rows: power code, sleep pin, converting, full down, partial down
  // each powered-down stretch lasts a few cycles, far short of the long-sleep limit
  task automatic t_power();
    logic [5:0] pt [7] = '{6'h02, 6'h08, 6'h04, 6'h10, 6'h26, 6'h31, 6'h34};
    for (int i = 0; i < 7; i++) begin
      sleepPinN = pt[i][3];
      converting = pt[i][2];
      host.reg_write(1'b0, 2'h0, pt[i][5:4]);
      tick(2);
      chk_val("power outs", {1'b0, pt[i][1:0]},
              {1'b0, fullPowerDown, partialPowerDown});
    end
    // sleep pin low in code 00 must wait for a calibration to finish
    sleepPinN = 1'b0;
    converting = 1'b0;
    host.reg_write(1'b1, 2'h2, 2'h0);
    chk_val("down while busy", 3'h0, {1'b0, fullPowerDown, partialPowerDown});
    run_cal(SGL, 3'h1);
    chk_val("down after cal", 3'h2, {1'b0, fullPowerDown, partialPowerDown});
  endtask : t_power
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // bounded run, far above the expected length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    sleepPinN = 1'b1;
    converting = 1'b0;
    convReq = 1'b0;
    tick(5);
    rst_n = 1'b1;
    tick(3);
    t_poweron();
    t_sw_types();
    t_slow();
    t_pin_type();
    t_refuse();
    t_power();
    print_verdict();
  end
endmodule : test_adcps_seq
`default_nettype wire
